// *** rtl/clk_ctrl_pkg.sv ***
// constants, register map and state types of the system and slow clock controller
package clk_ctrl_pkg;

	// timing
	localparam int CLK_FREQ_MHZ          = 200;
	localparam int XTAL_STARTUP_US       = 1000;
	localparam int XTAL_WAIT_CYC         = XTAL_STARTUP_US * CLK_FREQ_MHZ;
	localparam int SLOW_XTAL_STARTUP_MS  = 1000;
	localparam int SLOW_XTAL_WAIT_CYC    = SLOW_XTAL_STARTUP_MS * 1000 * CLK_FREQ_MHZ;

	// register byte offsets
	localparam logic [7:0] A_SYS_CTRL    = 8'h00;
	localparam logic [7:0] A_SYS_STAT    = 8'h04;
	localparam logic [7:0] A_HS_TRIM     = 8'h08;
	localparam logic [7:0] A_SLOW_CTRL   = 8'h0c;
	localparam logic [7:0] A_SLOW_STAT   = 8'h10;
	localparam logic [7:0] A_CAL_CTRL    = 8'h14;
	localparam logic [7:0] A_CAL_RESULT  = 8'h18;
	localparam logic [7:0] A_WAKE_LOAD   = 8'h1c;
	localparam logic [7:0] A_WAKE_STAT   = 8'h20;

	// field positions
	localparam int SYS_SEL_RC_BIT        = 0;
	localparam int SYS_MANUAL_BIT        = 1;
	localparam int CPU_DIV_LSB           = 2;
	localparam int SLOW_SRC_LSB          = 0;
	localparam int EXT_TRIM_LSB          = 4;
	localparam int CAL_START_BIT         = 0;
	localparam int CAL_DONE_BIT          = 31;
	localparam int WAKE_IRQ_BIT          = 0;
	localparam int WAKE_RUN_BIT          = 1;

	// reset values and limits
	localparam logic       SEL_RC_RST    = 1'b0;
	localparam logic       MANUAL_RST    = 1'b0;
	localparam logic [2:0] CPU_DIV_RST   = 3'h1;
	localparam logic [2:0] CPU_DIV_MAX   = 3'h5;
	localparam logic [2:0] PER_DIV_CODE  = 3'h1;
	localparam logic [7:0] HS_TRIM_RST   = 8'h00;
	localparam logic [3:0] EXT_TRIM_RST  = 4'h8;
	localparam logic [15:0] CAL_SLOW_CYCLES = 16'h0020;

	typedef enum logic [1:0] {
		SYS_RC   = 2'b00,
		SYS_WAIT = 2'b01,
		SYS_XTAL = 2'b10
	} sys_state_e;

	typedef enum logic [1:0] {
		SLOW_INT_RC     = 2'b00,
		SLOW_EXT_XTAL   = 2'b01,
		SLOW_EXT_MODULE = 2'b10
	} slow_src_e;

endpackage

// *** rtl/clk_switch.sv ***
// glitch-free two-way clock level selector
`timescale 1ns/1ps
module clk_switch
	import clk_ctrl_pkg::*;
(
	input  wire logic clk,
	input  wire logic srst,
	input  wire logic src_a,
	input  wire logic src_b,
	input  wire logic sel_b,
	output logic      clk_out_q,
	output logic      cur_b_q
);

	logic cur_d;
	wire  cur_lvl = cur_b_q ? src_b : src_a;
	wire  new_lvl = sel_b ? src_b : src_a;
	// hand over only while output, old and new source all sit low
	wire  swap_ok = (sel_b != cur_b_q) && !clk_out_q && !cur_lvl && !new_lvl;

	assign cur_d = swap_ok ? sel_b : cur_b_q;

	always_ff @(posedge clk) begin
		if (srst) begin
			cur_b_q   <= 1'b0;
			clk_out_q <= 1'b0;
		end else begin
			cur_b_q   <= cur_d;
			clk_out_q <= cur_d ? src_b : src_a;
		end
	end

	chk_switch_low_out: assert property (@(posedge clk) disable iff (srst) // R18
		$changed(cur_b_q) |-> !clk_out_q)
		else $error("clock source changed while output high");

endmodule

// *** rtl/clk_divider.sv ***
// glitch-free power-of-two divider of a sampled clock level
`timescale 1ns/1ps
module clk_divider
	import clk_ctrl_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       srst,
	input  wire logic       src,
	input  wire logic [2:0] div_code,
	output logic            clk_out_q,
	output logic [2:0]      code_q
);

	logic       prev_q;
	logic [4:0] cnt_q;
	logic [4:0] cnt_d;
	logic [2:0] code_d;

	function automatic logic out_bit(input logic [4:0] c, input logic [2:0] k, input logic s);
		case (k)
			3'h0:    out_bit = s;
			3'h1:    out_bit = c[0];
			3'h2:    out_bit = c[1];
			3'h3:    out_bit = c[2];
			3'h4:    out_bit = c[3];
			default: out_bit = c[4];
		endcase
	endfunction

	wire       rise = src && !prev_q;
	wire [4:0] mask = 5'((6'h01 << code_q) - 6'h01);
	// new ratio takes effect only where the counter wraps on a source rising edge
	wire       wrap = rise && ((cnt_q & mask) == mask);

	assign cnt_d  = wrap ? 5'h00 : (rise ? 5'(cnt_q + 5'h01) : cnt_q);
	assign code_d = wrap ? div_code : code_q;

	always_ff @(posedge clk) begin
		if (srst) begin
			prev_q    <= 1'b0;
			cnt_q     <= 5'h00;
			code_q    <= div_code;
			clk_out_q <= 1'b0;
		end else begin
			prev_q    <= src;
			cnt_q     <= cnt_d;
			code_q    <= code_d;
			clk_out_q <= out_bit(cnt_d, code_d, src) && !(code_d == 3'h0 && !src);
		end
	end

endmodule

// *** rtl/clk_ctrl.sv ***
// system, peripheral, cpu and slow clock controller with register port
//
// Function
// R01: RC first, auto switch to crystal after settling
// R02: same after sleep; manual option keeps RC
// R03: software source select; indicator false on crystal
// R04: peripheral clock is system clock halved
// R05: CPU clock defaults to system divided two
// R06: CPU divider 1, 2, 4, 8, 16, 32
// R07: fast RC trim from 27 to 32MHz
// R08: slow clock internal RC by default, external optional
// R09: external slow source is one-way, no return
// R10: blocking caller waits for slow crystal ready
// R11: non-blocking start switches immediately, ready later
// R12: slow crystal disables pin pull-ups, forces inputs
// R13: software clears pull-up before clock module; no register here clears it, slow_pullup_off_q stays 2'b00 for the module
// R14: clock module trim selects current and accuracy
// R15: slow clock calibrated against peripheral clock
// R16: slow clock runs wake timer raising wake interrupt
// R17: select slow crystal before timers are used
// R18: all source and divider changes glitch-free
//
// Our own choices: the address map and strobed register access.
`timescale 1ns/1ps
module clk_ctrl
	import clk_ctrl_pkg::*;
#(
	parameter int XTAL_WAIT      = XTAL_WAIT_CYC,
	parameter int SLOW_XTAL_WAIT = SLOW_XTAL_WAIT_CYC
) (
	input  wire logic        clk,
	input  wire logic        srst,
	input  wire logic [7:0]  addr,
	input  wire logic [31:0] wdata,
	input  wire logic        we,
	input  wire logic        re,
	output logic [31:0]      rdata_q,
	input  wire logic        hs_rc_osc,
	input  wire logic        xtal32m_osc,
	input  wire logic        rc32k_osc,
	input  wire logic        slow_clock_in_pin,
	input  wire logic        sleep_req,
	output logic             xtal32m_en_q,
	output logic [7:0]       hs_rc_trim_q,
	output logic             slow_xtal_en_q,
	output logic [3:0]       ext_rc_trim_q,
	output logic [1:0]       slow_pullup_off_q,
	output logic             slow_pins_input_q,
	output logic             sys_clk_q,
	output logic             per_clk_q,
	output logic             cpu_clk_q,
	output logic             slow_clk_q,
	output logic             wake_irq_q
);

	// pin synchronisers: {slow pin, rc32k, xtal, fast rc}
	logic [3:0] sync1_q;
	logic [3:0] sync2_q;

	always_ff @(posedge clk) begin
		if (srst) begin
			sync1_q <= 4'h0;
			sync2_q <= 4'h0;
		end else begin
			sync1_q <= {slow_clock_in_pin, rc32k_osc, xtal32m_osc, hs_rc_osc};
			sync2_q <= sync1_q;
		end
	end

	wire hs_rc_s   = sync2_q[0];
	wire xtal_s    = sync2_q[1];
	wire rc32k_s   = sync2_q[2];
	wire slow_in_s = sync2_q[3];

	// register strobes
	wire wr_sys_ctrl  = we && (addr == A_SYS_CTRL);
	wire wr_hs_trim   = we && (addr == A_HS_TRIM);
	wire wr_slow_ctrl = we && (addr == A_SLOW_CTRL);
	wire wr_cal_ctrl  = we && (addr == A_CAL_CTRL);
	wire wr_wake_load = we && (addr == A_WAKE_LOAD);
	wire wr_wake_stat = we && (addr == A_WAKE_STAT);

	// system clock source control
	logic        sel_rc_q;
	logic        manual_q;
	logic        sleep_prev_q;
	logic [2:0]  cpu_div_q;
	sys_state_e  sys_state_q;
	sys_state_e  sys_state_d;
	logic [31:0] xtal_cnt_q;
	logic        sys_on_xtal;
	logic [2:0]  cpu_code_act;

	wire        sleep_enter  = sleep_req && !sleep_prev_q;
	wire        xtal_want    = !sleep_req && !sel_rc_q;
	wire        xtal_settled = (xtal_cnt_q == 32'(XTAL_WAIT - 1));
	wire [2:0]  cpu_div_wr   = wdata[CPU_DIV_LSB +: 3];

	always_comb begin
		sys_state_d = sys_state_q;
		case (sys_state_q)
			SYS_RC: begin
				if (xtal_want) begin
					sys_state_d = SYS_WAIT; // R01 R02
				end
			end
			SYS_WAIT: begin
				if (!xtal_want) begin
					sys_state_d = SYS_RC;
				end else if (xtal_settled) begin
					sys_state_d = SYS_XTAL; // R01
				end
			end
			SYS_XTAL: begin
				if (!xtal_want) begin
					sys_state_d = SYS_RC; // R03
				end
			end
			default: sys_state_d = SYS_RC;
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			sys_state_q  <= SYS_RC;
			xtal_cnt_q   <= 32'h0000_0000;
			xtal32m_en_q <= 1'b0;
			sleep_prev_q <= 1'b0;
		end else begin
			sys_state_q  <= sys_state_d;
			xtal_cnt_q   <= (sys_state_q == SYS_WAIT && !xtal_settled) ? xtal_cnt_q + 32'h1 : 32'h0;
			xtal32m_en_q <= xtal_want;
			sleep_prev_q <= sleep_req;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			sel_rc_q     <= SEL_RC_RST;
			manual_q     <= MANUAL_RST;
			cpu_div_q    <= CPU_DIV_RST; // R05
			hs_rc_trim_q <= HS_TRIM_RST;
		end else begin
			if (sleep_enter && manual_q) begin
				sel_rc_q <= 1'b1; // R02
			end else if (wr_sys_ctrl) begin
				sel_rc_q <= wdata[SYS_SEL_RC_BIT]; // R03
			end
			if (wr_sys_ctrl) begin
				manual_q <= wdata[SYS_MANUAL_BIT];
			end
			if (wr_sys_ctrl && cpu_div_wr <= CPU_DIV_MAX) begin
				cpu_div_q <= cpu_div_wr; // R06
			end
			if (wr_hs_trim) begin
				hs_rc_trim_q <= wdata[7:0]; // R07
			end
		end
	end

	clk_switch u_sys_switch (
		.clk       (clk),
		.srst      (srst),
		.src_a     (hs_rc_s),
		.src_b     (xtal_s),
		.sel_b     (sys_state_q == SYS_XTAL),
		.clk_out_q (sys_clk_q),
		.cur_b_q   (sys_on_xtal)
	);

	clk_divider u_per_div (
		.clk       (clk),
		.srst      (srst),
		.src       (sys_clk_q),
		.div_code  (PER_DIV_CODE), // R04
		.clk_out_q (per_clk_q),
		.code_q    ()
	);

	clk_divider u_cpu_div (
		.clk       (clk),
		.srst      (srst),
		.src       (sys_clk_q),
		.div_code  (cpu_div_q), // R05 R06 R18
		.clk_out_q (cpu_clk_q),
		.code_q    (cpu_code_act)
	);

	// slow clock domain source
	slow_src_e   slow_src_q;
	slow_src_e   slow_src_d;
	logic [31:0] slow_cnt_q;
	logic        slow_ready_q;
	logic        slow_on_ext;

	wire [1:0] slow_src_wr = wdata[SLOW_SRC_LSB +: 2];
	wire       slow_take   = wr_slow_ctrl && (slow_src_q == SLOW_INT_RC) &&
	                         (slow_src_wr == SLOW_EXT_XTAL || slow_src_wr == SLOW_EXT_MODULE);

	assign slow_src_d = slow_take ? slow_src_e'(slow_src_wr) : slow_src_q; // R09

	always_ff @(posedge clk) begin
		if (srst) begin
			slow_src_q        <= SLOW_INT_RC; // R08
			slow_xtal_en_q    <= 1'b0;
			slow_cnt_q        <= 32'h0000_0000;
			slow_ready_q      <= 1'b0;
			ext_rc_trim_q     <= EXT_TRIM_RST;
			slow_pullup_off_q <= 2'b00;
			slow_pins_input_q <= 1'b0;
		end else begin
			slow_src_q        <= slow_src_d;
			slow_xtal_en_q    <= (slow_src_d == SLOW_EXT_XTAL); // R11
			if (slow_src_q == SLOW_EXT_XTAL && !slow_ready_q) begin
				slow_cnt_q <= slow_cnt_q + 32'h1;
			end
			slow_ready_q      <= (slow_src_d != SLOW_EXT_XTAL) || ((slow_src_q == SLOW_EXT_XTAL) &&
			                     (slow_ready_q || slow_cnt_q == 32'(SLOW_XTAL_WAIT - 1))); // R10 R11
			if (wr_slow_ctrl) begin
				ext_rc_trim_q <= wdata[EXT_TRIM_LSB +: 4]; // R14
			end
			// module case keeps both pull-ups on, no register clears them
			slow_pullup_off_q <= {2{slow_src_d == SLOW_EXT_XTAL}}; // R12
			slow_pins_input_q <= (slow_src_d != SLOW_INT_RC); // R12
		end
	end

	clk_switch u_slow_switch (
		.clk       (clk),
		.srst      (srst),
		.src_a     (rc32k_s),
		.src_b     (slow_in_s),
		.sel_b     (slow_src_q != SLOW_INT_RC), // R08 R11 R18
		.clk_out_q (slow_clk_q),
		.cur_b_q   (slow_on_ext)
	);

	// edge detect of slow and peripheral clocks
	logic slow_prev_q;
	logic per_prev_q;

	always_ff @(posedge clk) begin
		if (srst) begin
			slow_prev_q <= 1'b0;
			per_prev_q  <= 1'b0;
		end else begin
			slow_prev_q <= slow_clk_q;
			per_prev_q  <= per_clk_q;
		end
	end

	wire slow_rise = slow_clk_q && !slow_prev_q;
	wire per_rise  = per_clk_q && !per_prev_q;

	// calibration: peripheral edges over a fixed count of slow edges
	logic        cal_run_q;
	logic        cal_done_q;
	logic [15:0] cal_slow_q;
	logic [23:0] cal_per_q;

	wire cal_last = cal_run_q && slow_rise && (cal_slow_q == CAL_SLOW_CYCLES - 16'h1);

	always_ff @(posedge clk) begin
		if (srst) begin
			cal_run_q  <= 1'b0;
			cal_done_q <= 1'b0;
			cal_slow_q <= 16'h0000;
			cal_per_q  <= 24'h000000;
		end else if (wr_cal_ctrl && wdata[CAL_START_BIT]) begin
			cal_run_q  <= 1'b1; // R15
			cal_done_q <= 1'b0;
			cal_slow_q <= 16'h0000;
			cal_per_q  <= 24'h000000;
		end else if (cal_run_q) begin
			if (per_rise) begin
				cal_per_q <= cal_per_q + 24'h1; // R15
			end
			if (slow_rise) begin
				cal_slow_q <= cal_slow_q + 16'h1;
			end
			if (cal_last) begin
				cal_run_q  <= 1'b0;
				cal_done_q <= 1'b1;
			end
		end
	end

	// wake timer on the slow clock
	logic        wake_run_q;
	logic [31:0] wake_cnt_q;

	wire wake_fire = wake_run_q && slow_rise && (wake_cnt_q == 32'h1);
	wire wake_clr  = wr_wake_stat && wdata[WAKE_IRQ_BIT];

	always_ff @(posedge clk) begin
		if (srst) begin
			wake_run_q <= 1'b0;
			wake_cnt_q <= 32'h0000_0000;
			wake_irq_q <= 1'b0;
		end else begin
			if (wr_wake_load) begin
				wake_cnt_q <= wdata;
				wake_run_q <= (wdata != 32'h0);
			end else if (wake_run_q && slow_rise) begin
				wake_cnt_q <= wake_cnt_q - 32'h1; // R16
				wake_run_q <= !wake_fire;
			end
			wake_irq_q <= wake_fire || (wake_irq_q && !wake_clr); // R16
		end
	end

	// read path
	logic [31:0] rdata_d;

	always_comb begin
		rdata_d = 32'h0000_0000;
		if (addr == A_SYS_CTRL) begin
			rdata_d = {27'h0, cpu_div_q, manual_q, sel_rc_q};
		end else if (addr == A_SYS_STAT) begin
			rdata_d = {26'h0, cpu_code_act, sys_state_q == SYS_WAIT, xtal32m_en_q, !sys_on_xtal}; // R03
		end else if (addr == A_HS_TRIM) begin
			rdata_d = {24'h0, hs_rc_trim_q};
		end else if (addr == A_SLOW_CTRL) begin
			rdata_d = {24'h0, ext_rc_trim_q, 2'b00, slow_src_q};
		end else if (addr == A_SLOW_STAT) begin
			rdata_d = {30'h0, slow_on_ext, slow_ready_q}; // R10
		end else if (addr == A_CAL_CTRL) begin
			rdata_d = {31'h0, cal_run_q};
		end else if (addr == A_CAL_RESULT) begin
			rdata_d = {cal_done_q, 7'h0, cal_per_q};
		end else if (addr == A_WAKE_LOAD) begin
			rdata_d = wake_cnt_q;
		end else if (addr == A_WAKE_STAT) begin
			rdata_d = {30'h0, wake_run_q, wake_irq_q};
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			rdata_q <= 32'h0000_0000;
		end else begin
			rdata_q <= re ? rdata_d : 32'h0000_0000;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	chk_rc_after_reset: assert property ($fell(srst) |-> !sys_on_xtal && sys_state_q == SYS_RC) // R01
		else $error("system clock not on fast RC after reset");
	chk_xtal_settle: assert property ($rose(sys_state_q == SYS_XTAL) |-> $past(xtal_settled)) // R01
		else $error("crystal selected before settle count");
	chk_manual_sleep: assert property (sleep_enter && manual_q |=> sel_rc_q ##1 !xtal32m_en_q) // R02
		else $error("manual fast start did not keep RC");
	chk_src_indicator: assert property (re && addr == A_SYS_STAT |=> rdata_q[0] == $past(!sys_on_xtal)) // R03
		else $error("source indicator wrong");
	chk_per_half: assert property ($changed(per_clk_q) |-> $past(sys_clk_q) && !$past(sys_clk_q, 2)) // R04
		else $error("peripheral clock moved without system edge");
	chk_cpu_default: assert property ($fell(srst) |-> cpu_div_q == CPU_DIV_RST) // R05
		else $error("cpu divider default wrong");
	chk_cpu_div_range: assert property (cpu_div_q <= CPU_DIV_MAX) // R06
		else $error("cpu divider out of range");
	chk_slow_oneway: assert property (slow_src_q != SLOW_INT_RC |=> slow_src_q == $past(slow_src_q)) // R09
		else $error("slow source left external");
	chk_xtal_pins: assert property (slow_src_q == SLOW_EXT_XTAL |-> slow_pullup_off_q == 2'b11 && slow_pins_input_q) // R12
		else $error("slow crystal pins not released");
	chk_wake_fire: assert property (wake_fire && !wr_wake_load |=> wake_irq_q && !wake_run_q) // R16
		else $error("wake timer expiry lost");

	cov_auto_xtal: cover property ($rose(sys_on_xtal));
	cov_slow_xtal: cover property ($rose(slow_ready_q) && slow_src_q == SLOW_EXT_XTAL);
	cov_wake: cover property ($rose(wake_irq_q));

endmodule

// *** sim/osc_model.sv ***
// oscillators and slow pin source standing outside the clock controller
`timescale 1ns/1ps
module osc_model #(
	parameter int XP = 60,
	parameter int RP = 70,
	parameter int SP = 400,
	parameter int PP = 500
) (
	input  wire logic xtal_en,
	input  wire logic slow_xtal_en,
	input  wire logic module_on,
	output logic      hs_rc_osc,
	output logic      xtal32m_osc,
	output logic      rc32k_osc,
	output logic      slow_pin
);
	logic pin_osc;

	initial begin
		hs_rc_osc = 1'h0;
		xtal32m_osc = 1'h0;
		rc32k_osc = 1'h0;
		pin_osc = 1'h0;
	end

	always #(RP/2) hs_rc_osc = ~hs_rc_osc;
	always #(SP/2) rc32k_osc = ~rc32k_osc;
	// crystal stands still until enabled
	always #(XP/2) xtal32m_osc = xtal_en ? ~xtal32m_osc : 1'h0;
	always #(PP/2) pin_osc = ~pin_osc;
	// undriven pin floats to its pull-up level
	assign slow_pin = (slow_xtal_en | module_on) ? pin_osc : 1'h1;
endmodule

// *** sim/system_and_slow_clock_control_tb_top.sv ***
// self-checking bench of the system and slow clock controller
`timescale 1ns/1ps
module system_and_slow_clock_control_tb_top
	import clk_ctrl_pkg::*;
;
	localparam int XP = 60;
	localparam int SP = 400;
	localparam int PP = 500;
	typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] r; int div;} row_s;
	logic        clk = 1'h0;
	logic        srst = 1'h1;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic        we = 1'h0;
	logic        re = 1'h0;
	logic        sleep_req = 1'h0;
	logic        module_on = 1'h0;
	logic [31:0] rdata_q, d;
	logic        hs_rc_osc, xtal32m_osc, rc32k_osc, slow_clock_in_pin;
	logic        xtal32m_en_q, slow_xtal_en_q, slow_pins_input_q;
	logic [7:0]  hs_rc_trim_q;
	logic [3:0]  ext_rc_trim_q;
	logic [1:0]  slow_pullup_off_q;
	logic        sys_clk_q, per_clk_q, cpu_clk_q, slow_clk_q, wake_irq_q;
	int          bad_count = 0;
	int          n_tests = 0;
	int          ns, np, nc, nw;
	row_s        rows [10];

	always #2.5 clk = ~clk;

	clk_ctrl #(.XTAL_WAIT(16), .SLOW_XTAL_WAIT(32)) u_dut (
		.clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .we(we), .re(re), .rdata_q(rdata_q),
		.hs_rc_osc(hs_rc_osc), .xtal32m_osc(xtal32m_osc), .rc32k_osc(rc32k_osc),
		.slow_clock_in_pin(slow_clock_in_pin), .sleep_req(sleep_req), .xtal32m_en_q(xtal32m_en_q),
		.hs_rc_trim_q(hs_rc_trim_q), .slow_xtal_en_q(slow_xtal_en_q), .ext_rc_trim_q(ext_rc_trim_q),
		.slow_pullup_off_q(slow_pullup_off_q), .slow_pins_input_q(slow_pins_input_q),
		.sys_clk_q(sys_clk_q), .per_clk_q(per_clk_q), .cpu_clk_q(cpu_clk_q),
		.slow_clk_q(slow_clk_q), .wake_irq_q(wake_irq_q));

	osc_model #(.XP(XP), .RP(70), .SP(SP), .PP(PP)) u_osc (
		.xtal_en(xtal32m_en_q), .slow_xtal_en(slow_xtal_en_q), .module_on(module_on),
		.hs_rc_osc(hs_rc_osc), .xtal32m_osc(xtal32m_osc), .rc32k_osc(rc32k_osc),
		.slow_pin(slow_clock_in_pin));

	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	function automatic logic [31:0] near(input int a, input int e, input int t);
		return {31'h0, (a - e <= t) && (e - a <= t)};
	endfunction

	task automatic wr(input logic [7:0] a, input logic [31:0] w);
		@(posedge clk);
		we    <= 1'h1;
		addr  <= a;
		wdata <= w;
		@(posedge clk);
		we <= 1'h0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		re   <= 1'h1;
		addr <= a;
		@(posedge clk);
		re <= 1'h0;
		#1 d = rdata_q;
	endtask

	// reads until the bit takes the value or the limit runs out, then compares
	task automatic poll(input logic [7:0] a, input int b, input logic v);
		int i;
		i = 0;
		rd(a);
		while (d[b] !== v && i < 2000) begin
			rd(a);
			i++;
		end
		chk({31'h0, d[b]}, {31'h0, v});
	endtask

	// counts rising edges of the clock outputs after the divider has settled
	task automatic meas();
		logic ps, pp, pc, pw;
		repeat (500) @(posedge clk);
		#1;
		ns = 0;
		np = 0;
		nc = 0;
		nw = 0;
		{ps, pp, pc, pw} = {sys_clk_q, per_clk_q, cpu_clk_q, slow_clk_q};
		repeat (2000) begin
			@(posedge clk);
			#1;
			ns += int'(sys_clk_q & ~ps);
			np += int'(per_clk_q & ~pp);
			nc += int'(cpu_clk_q & ~pc);
			nw += int'(slow_clk_q & ~pw);
			{ps, pp, pc, pw} = {sys_clk_q, per_clk_q, cpu_clk_q, slow_clk_q};
		end
	endtask

	task automatic rst();
		@(posedge clk);
		srst <= 1'h1;
		repeat (4) @(posedge clk);
		srst <= 1'h0;
	endtask

	initial begin
		#400000;
		bad_count++;
		stop_test();
	end

	initial begin
		rows = '{
			'{A_SYS_CTRL, 32'h04, 32'h04, 2},
			'{A_SYS_CTRL, 32'h00, 32'h00, 1},
			'{A_SYS_CTRL, 32'h08, 32'h08, 4},
			'{A_SYS_CTRL, 32'h0c, 32'h0c, 8},
			'{A_SYS_CTRL, 32'h10, 32'h10, 16},
			'{A_SYS_CTRL, 32'h14, 32'h14, 32},
			'{A_SYS_CTRL, 32'h18, 32'h14, 32},
			'{A_HS_TRIM, 32'ha5, 32'ha5, 0},
			'{8'h30, 32'h5a, 32'h00, 0},
			'{A_SLOW_CTRL, 32'h30, 32'h30, 0}};
		repeat (2) @(posedge clk);
		srst <= 1'h0;
		@(posedge clk);
		#1 chk({hs_rc_trim_q, ext_rc_trim_q, slow_pullup_off_q, slow_pins_input_q, wake_irq_q}, 32'h0080);
		rd(A_SYS_STAT);
		chk(d, 32'h0f);
		rd(A_SYS_CTRL);
		chk(d, 32'h04);
		poll(A_SYS_STAT, 0, 1'h0);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].w);
			rd(rows[i].a);
			chk(d, rows[i].r);
			if (rows[i].div > 0) begin
				meas();
				chk(near(ns, nc * rows[i].div, rows[i].div + 1), 32'h1);
				chk(near(ns, np * 2, 2), 32'h1);
			end
		end
		chk(hs_rc_trim_q, 8'ha5);
		wr(A_SYS_CTRL, 32'h06);
		sleep_req <= 1'h1;
		poll(A_SYS_STAT, 0, 1'h1);
		sleep_req <= 1'h0;
		repeat (40) @(posedge clk);
		rd(A_SYS_STAT);
		chk(d[1:0], 2'h1);
		rd(A_SYS_CTRL);
		chk(d, 32'h07);
		wr(A_SYS_CTRL, 32'h04);
		poll(A_SYS_STAT, 0, 1'h0);
		sleep_req <= 1'h1;
		poll(A_SYS_STAT, 0, 1'h1);
		chk(xtal32m_en_q, 1'h0);
		sleep_req <= 1'h0;
		poll(A_SYS_STAT, 0, 1'h0);
		wr(A_SYS_CTRL, 32'h05);
		poll(A_SYS_STAT, 0, 1'h1);
		chk(xtal32m_en_q, 1'h0);
		wr(A_SYS_CTRL, 32'h04);
		poll(A_SYS_STAT, 0, 1'h0);
		wr(A_CAL_CTRL, 32'h1);
		poll(A_CAL_RESULT, 31, 1'h1);
		chk(near(int'(d[23:0]), 32 * SP / (2 * XP), 4), 32'h1);
		rst();
		rd(A_SLOW_STAT);
		chk(d, 32'h1);
		meas();
		chk(near(nw, 10000 / SP, 2), 32'h1);
		wr(A_SLOW_CTRL, 32'h1);
		rd(A_SLOW_STAT);
		chk(d, 32'h0);
		chk({slow_xtal_en_q, slow_pullup_off_q, slow_pins_input_q}, 4'hf);
		poll(A_SLOW_STAT, 1, 1'h1);
		poll(A_SLOW_STAT, 0, 1'h1);
		wr(A_SLOW_CTRL, 32'h0);
		wr(A_SLOW_CTRL, 32'h2);
		rd(A_SLOW_CTRL);
		chk(d[1:0], 2'h1);
		meas();
		chk(near(nw, 10000 / PP, 2), 32'h1);
		wr(A_WAKE_LOAD, 32'h2);
		rd(A_WAKE_STAT);
		chk(d[1:0], 2'h2);
		poll(A_WAKE_STAT, 0, 1'h1);
		chk(wake_irq_q, 1'h1);
		wr(A_WAKE_STAT, 32'h1);
		rd(A_WAKE_STAT);
		chk({d[0], wake_irq_q}, 2'h0);
		rst();
		module_on <= 1'h1;
		wr(A_SLOW_CTRL, 32'h32);
		#1;
		chk({ext_rc_trim_q, slow_pullup_off_q, slow_pins_input_q, slow_xtal_en_q}, 8'h32);
		poll(A_SLOW_STAT, 1, 1'h1);
		chk(d[1:0], 2'h3);
		wr(A_SLOW_CTRL, 32'h1);
		rd(A_SLOW_CTRL);
		chk(d[1:0], 2'h2);
		stop_test();
	end
endmodule
